// ===== rtl/dcfm_pkg.sv
// Shared constants, types and helpers for the dual clock queue with mailboxes.
// Assumes two free-running port clocks and a 36-bit word of four parity lanes.
package dcfm_pkg;

    localparam int DEPTH = 64; // Queue locations
    localparam int WIDTH = 36; // Word width
    localparam int PTR_W = 7; // Pointer width with wrap bit
    localparam int ADDR_W = 6; // Memory index width
    localparam int LANES = 4; // Parity lanes per word
    localparam int LANE_W = 9; // Eight data bits and one parity bit

    typedef logic [WIDTH-1:0] dcfm_word_t; // One stored word
    typedef logic [PTR_W-1:0] dcfm_ptr_t; // Pointer or count

    // Control strobes of one port, sampled on that port's rising edge
    typedef struct packed {
        logic select_n; // Port chip select, active low
        logic qualify; // Port enable, active high
        logic write; // High writes, low reads
        logic mail_select; // High picks a mailbox
    } dcfm_ctl_s;

    localparam dcfm_ptr_t DEPTH_CNT = 7'h40; // Count of a full queue
    localparam dcfm_ptr_t PTR_RESET = 7'h00; // Pointer reset value
    localparam dcfm_word_t WORD_RESET = 36'h0; // Data register reset value
    localparam logic [1:0] READY_RESET = 2'h0; // Flag release pipe at reset
    // Four offset presets chosen by the strap at reset release
    localparam dcfm_ptr_t OFFSET_PRESET_0 = 7'h10;
    localparam dcfm_ptr_t OFFSET_PRESET_1 = 7'h0c;
    localparam dcfm_ptr_t OFFSET_PRESET_2 = 7'h08;
    localparam dcfm_ptr_t OFFSET_PRESET_3 = 7'h04;

    // Binary to Gray
    function automatic dcfm_ptr_t bin2gray(input dcfm_ptr_t b);
        return b ^ (b >> 1);
    endfunction

    // Gray to binary
    function automatic dcfm_ptr_t gray2bin(input dcfm_ptr_t g);
        dcfm_ptr_t b;
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // High when every lane carries the selected parity
    function automatic logic parity_ok(input dcfm_word_t w, input logic odd);
        logic ok;
        ok = 1'b1;
        for (int l = 0; l < LANES; l++) begin
            if ((^w[l*LANE_W +: LANE_W]) != odd) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // Replaces each lane's parity bit with a generated one
    function automatic dcfm_word_t parity_fill(input dcfm_word_t w,
                                               input logic odd);
        dcfm_word_t r;
        r = w;
        for (int l = 0; l < LANES; l++) begin
            r[l*LANE_W+8] = (^w[l*LANE_W +: 8]) ^ odd;
        end
        return r;
    endfunction

    // Offset preset picked by the two select straps
    function automatic dcfm_ptr_t offset_preset(input logic [1:0] sel);
        dcfm_ptr_t v;
        if (sel == 2'h0) begin
            v = OFFSET_PRESET_0;
        end else if (sel == 2'h1) begin
            v = OFFSET_PRESET_1;
        end else if (sel == 2'h2) begin
            v = OFFSET_PRESET_2;
        end else begin
            v = OFFSET_PRESET_3;
        end
        return v;
    endfunction

endpackage

// ===== rtl/dcfm_ptr_sync.sv
// Two-stage synchroniser for a Gray-coded queue pointer.
// Assumes the Gray input comes straight from a flop in the other domain.
`timescale 1ns/1ps
module dcfm_ptr_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire dcfm_pkg::dcfm_ptr_t gray_in,
    output dcfm_pkg::dcfm_ptr_t bin_out
);
    import dcfm_pkg::*;

    dcfm_ptr_t stage1_ff; // First stage, read only by the second
    dcfm_ptr_t stage2_ff; // Second stage
    dcfm_ptr_t nxt_stage1;
    dcfm_ptr_t nxt_stage2;

    // Next values of the two stages
    always_comb begin
        nxt_stage1 = gray_in;
        nxt_stage2 = stage1_ff;
    end

    // Stage registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stage1_ff <= PTR_RESET;
            stage2_ff <= PTR_RESET;
        end else begin
            stage1_ff <= nxt_stage1;
            stage2_ff <= nxt_stage2;
        end
    end

    // Binary pointer in the local domain
    assign bin_out = gray2bin(stage2_ff);

endmodule

// ===== rtl/dcfm_top.sv
// Dual clock 64 x 36 queue from port A to port B with two mailboxes.
// Assumes reset_n is held low across at least two edges of both clocks.
//
// How it works
// - Queue of 64 words, 36 bits, in order.
// - Transfers only on qualified rising clock edges.
// - Port clocks independent; simultaneous write and read.
// - Full flags built in port A domain.
// - Empty flags built in port B domain.
// - Near-empty low when stored words <= offset.
// - Near-full low when free slots <= offset.
// - Two 36-bit mailboxes, one each direction.
// - Each mailbox flags new mail pending.
// - Parity checked, never blocks the transfer.
// - Optional generated parity on reads, per port.
// - Port A bus released while select high.
// - Bidirectional buses driven only during reads.
// - Full low in reset, high second edge after.
// - Empty low when empty, rises second edge.
// - Reset release latches offset preset select.
`timescale 1ns/1ps
module dcfm_top (
    input wire logic port_a_clock,
    input wire logic port_b_clock,
    input wire logic reset_n,
    input wire logic [1:0] offset_preset_select,
    input wire logic parity_odd,
    input wire logic port_a_parity_gen,
    input wire logic port_b_parity_gen,
    input wire dcfm_pkg::dcfm_ctl_s port_a_ctl,
    input wire dcfm_pkg::dcfm_ctl_s port_b_ctl,
    input wire dcfm_pkg::dcfm_word_t port_a_bus_in,
    output dcfm_pkg::dcfm_word_t port_a_bus_out,
    output logic port_a_bus_oe,
    input wire dcfm_pkg::dcfm_word_t port_b_bus_in,
    output dcfm_pkg::dcfm_word_t port_b_bus_out,
    output logic port_b_bus_oe,
    output logic full_indicator_n,
    output logic near_full_flag_n,
    output logic empty_indicator_n,
    output logic near_empty_flag_n,
    output logic mail_one_pending_n,
    output logic mail_two_pending_n,
    output logic port_a_parity_ok,
    output logic port_b_parity_ok
);
    import dcfm_pkg::*;

    dcfm_word_t mem [DEPTH]; // Queue storage, written on port A
    // Port A domain state
    dcfm_ptr_t wr_bin_ff, nxt_wr_bin; // Write pointer
    dcfm_ptr_t wr_gray_ff, nxt_wr_gray; // Write pointer for crossing
    dcfm_ptr_t offset_a_ff, nxt_offset_a; // Near-full offset
    logic [1:0] ready_a_ff, nxt_ready_a; // Release pipe after reset
    dcfm_word_t mail_one_ff, nxt_mail_one; // Mailbox A to B
    logic wr1_tgl_ff, nxt_wr1_tgl; // Toggles on each mail one write
    logic rd2_tgl_ff, nxt_rd2_tgl; // Toggles on each mail two take
    dcfm_word_t a_out_ff, nxt_a_out; // Port A output register
    logic a_par_ff, nxt_a_par; // Port A parity status
    logic [1:0] a_s1_ff, a_s2_ff; // Toggle syncs: {rd1, wr2}
    // Port B domain state
    dcfm_ptr_t rd_bin_ff, nxt_rd_bin; // Read pointer
    dcfm_ptr_t rd_gray_ff, nxt_rd_gray; // Read pointer for crossing
    dcfm_ptr_t offset_b_ff, nxt_offset_b; // Near-empty offset
    logic [1:0] ready_b_ff, nxt_ready_b;
    dcfm_word_t mail_two_ff, nxt_mail_two; // Mailbox B to A
    logic wr2_tgl_ff, nxt_wr2_tgl;
    logic rd1_tgl_ff, nxt_rd1_tgl;
    dcfm_word_t b_out_ff, nxt_b_out;
    logic b_par_ff, nxt_b_par;
    logic [1:0] b_s1_ff, b_s2_ff; // Toggle syncs: {rd2, wr1}

    dcfm_ptr_t rd_in_a, wr_in_b; // Far pointers after crossing
    dcfm_ptr_t count_a, count_b; // Occupancy seen by each side
    logic a_act, b_act; // Qualified edge on each port
    logic a_fifo_wr, a_mail1_wr, a_mail2_rd, a_mail2_new;
    logic b_fifo_rd, b_mail2_wr, b_mail1_rd, b_mail1_new;

    // Gray pointers cross into the far domain
    dcfm_ptr_sync u_rd_to_a (
        .clk(port_a_clock), .reset_n(reset_n),
        .gray_in(rd_gray_ff), .bin_out(rd_in_a)
    );
    dcfm_ptr_sync u_wr_to_b (
        .clk(port_b_clock), .reset_n(reset_n),
        .gray_in(wr_gray_ff), .bin_out(wr_in_b)
    );

    // Port A decode: select low and qualify high gate the edge
    always_comb begin
        a_act = reset_n & ~port_a_ctl.select_n & port_a_ctl.qualify;
        count_a = wr_bin_ff - rd_in_a;
        full_indicator_n = ready_a_ff[1] & (count_a != DEPTH_CNT);
        near_full_flag_n = ready_a_ff[1] &
                           ((DEPTH_CNT - count_a) > offset_a_ff);
        mail_one_pending_n = ~(wr1_tgl_ff ^ a_s2_ff[1]);
        a_mail2_new = rd2_tgl_ff ^ a_s2_ff[0];
        // Writes are refused while full
        a_fifo_wr = a_act & port_a_ctl.write & ~port_a_ctl.mail_select &
                    full_indicator_n;
        a_mail1_wr = a_act & port_a_ctl.write & port_a_ctl.mail_select &
                     mail_one_pending_n;
        a_mail2_rd = a_act & ~port_a_ctl.write & port_a_ctl.mail_select;
    end

    // Port A next state
    always_comb begin
        nxt_ready_a = {ready_a_ff[0], 1'b1};
        // Offset taken on the first edge after reset release
        nxt_offset_a = ready_a_ff[0] ? offset_a_ff :
                       offset_preset(offset_preset_select);
        nxt_wr_bin = wr_bin_ff + (a_fifo_wr ? 7'h01 : 7'h00);
        nxt_wr_gray = bin2gray(nxt_wr_bin);
        nxt_mail_one = a_mail1_wr ? port_a_bus_in : mail_one_ff;
        nxt_wr1_tgl = wr1_tgl_ff ^ a_mail1_wr;
        nxt_rd2_tgl = rd2_tgl_ff ^ (a_mail2_rd & a_mail2_new);
        nxt_a_out = a_out_ff;
        if (a_mail2_rd) begin
            // Generated parity replaces the stored bits
            nxt_a_out = port_a_parity_gen ?
                        parity_fill(mail_two_ff, parity_odd) : mail_two_ff;
        end
        // Checked on every write, the word is kept anyway
        nxt_a_par = (a_act & port_a_ctl.write) ?
                    parity_ok(port_a_bus_in, parity_odd) : a_par_ff;
    end

    // Port A registers
    always_ff @(posedge port_a_clock) begin
        if (!reset_n) begin
            ready_a_ff <= READY_RESET;
            offset_a_ff <= OFFSET_PRESET_0;
            wr_bin_ff <= PTR_RESET;
            wr_gray_ff <= PTR_RESET;
            mail_one_ff <= WORD_RESET;
            wr1_tgl_ff <= 1'b0;
            rd2_tgl_ff <= 1'b0;
            a_out_ff <= WORD_RESET;
            a_par_ff <= 1'b1;
            a_s1_ff <= 2'h0;
            a_s2_ff <= 2'h0;
        end else begin
            ready_a_ff <= nxt_ready_a;
            offset_a_ff <= nxt_offset_a;
            wr_bin_ff <= nxt_wr_bin;
            wr_gray_ff <= nxt_wr_gray;
            mail_one_ff <= nxt_mail_one;
            wr1_tgl_ff <= nxt_wr1_tgl;
            rd2_tgl_ff <= nxt_rd2_tgl;
            a_out_ff <= nxt_a_out;
            a_par_ff <= nxt_a_par;
            a_s1_ff <= {rd1_tgl_ff, wr2_tgl_ff};
            a_s2_ff <= a_s1_ff;
        end
    end

    // Queue storage write on port A
    always_ff @(posedge port_a_clock) begin
        if (a_fifo_wr) begin
            mem[wr_bin_ff[ADDR_W-1:0]] <= port_a_bus_in;
        end
    end

    // Port B decode
    always_comb begin
        b_act = reset_n & ~port_b_ctl.select_n & port_b_ctl.qualify;
        count_b = wr_in_b - rd_bin_ff;
        empty_indicator_n = ready_b_ff[1] & (count_b != PTR_RESET);
        near_empty_flag_n = ready_b_ff[1] & (count_b > offset_b_ff);
        mail_two_pending_n = ~(wr2_tgl_ff ^ b_s2_ff[1]);
        b_mail1_new = rd1_tgl_ff ^ b_s2_ff[0];
        // Reads are refused while empty
        b_fifo_rd = b_act & ~port_b_ctl.write & ~port_b_ctl.mail_select &
                    empty_indicator_n;
        b_mail1_rd = b_act & ~port_b_ctl.write & port_b_ctl.mail_select;
        b_mail2_wr = b_act & port_b_ctl.write & port_b_ctl.mail_select &
                     mail_two_pending_n;
    end

    // Port B next state
    always_comb begin
        nxt_ready_b = {ready_b_ff[0], 1'b1};
        nxt_offset_b = ready_b_ff[0] ? offset_b_ff :
                       offset_preset(offset_preset_select);
        nxt_rd_bin = rd_bin_ff + (b_fifo_rd ? 7'h01 : 7'h00);
        nxt_rd_gray = bin2gray(nxt_rd_bin);
        nxt_mail_two = b_mail2_wr ? port_b_bus_in : mail_two_ff;
        nxt_wr2_tgl = wr2_tgl_ff ^ b_mail2_wr;
        nxt_rd1_tgl = rd1_tgl_ff ^ (b_mail1_rd & b_mail1_new);
        nxt_b_out = b_out_ff;
        if (b_fifo_rd) begin
            nxt_b_out = port_b_parity_gen ?
                parity_fill(mem[rd_bin_ff[ADDR_W-1:0]], parity_odd) :
                mem[rd_bin_ff[ADDR_W-1:0]];
        end else if (b_mail1_rd) begin
            nxt_b_out = port_b_parity_gen ?
                        parity_fill(mail_one_ff, parity_odd) : mail_one_ff;
        end
        nxt_b_par = (b_act & port_b_ctl.write) ?
                    parity_ok(port_b_bus_in, parity_odd) : b_par_ff;
    end

    // Port B registers
    always_ff @(posedge port_b_clock) begin
        if (!reset_n) begin
            ready_b_ff <= READY_RESET;
            offset_b_ff <= OFFSET_PRESET_0;
            rd_bin_ff <= PTR_RESET;
            rd_gray_ff <= PTR_RESET;
            mail_two_ff <= WORD_RESET;
            wr2_tgl_ff <= 1'b0;
            rd1_tgl_ff <= 1'b0;
            b_out_ff <= WORD_RESET;
            b_par_ff <= 1'b1;
            b_s1_ff <= 2'h0;
            b_s2_ff <= 2'h0;
        end else begin
            ready_b_ff <= nxt_ready_b;
            offset_b_ff <= nxt_offset_b;
            rd_bin_ff <= nxt_rd_bin;
            rd_gray_ff <= nxt_rd_gray;
            mail_two_ff <= nxt_mail_two;
            wr2_tgl_ff <= nxt_wr2_tgl;
            rd1_tgl_ff <= nxt_rd1_tgl;
            b_out_ff <= nxt_b_out;
            b_par_ff <= nxt_b_par;
            b_s1_ff <= {rd2_tgl_ff, wr1_tgl_ff};
            b_s2_ff <= b_s1_ff;
        end
    end

    // Buses driven only for a selected read
    assign port_a_bus_oe = ~port_a_ctl.select_n & ~port_a_ctl.write;
    assign port_b_bus_oe = ~port_b_ctl.select_n & ~port_b_ctl.write;
    assign port_a_bus_out = a_out_ff;
    assign port_b_bus_out = b_out_ff;
    assign port_a_parity_ok = a_par_ff;
    assign port_b_parity_ok = b_par_ff;

    // Checks
    sequence s_full_release;
        !full_indicator_n ##1 !full_indicator_n ##1 full_indicator_n;
    endsequence
    property p_full_release;
        @(posedge port_a_clock) $rose(reset_n) |-> s_full_release;
    endproperty
    a_full_release: assert property (p_full_release)
        else $error("full flag not released on second edge");
    property p_full_blocks;
        @(posedge port_a_clock) disable iff (!reset_n)
        !full_indicator_n |=> wr_bin_ff == $past(wr_bin_ff);
    endproperty
    a_full_blocks: assert property (p_full_blocks)
        else $error("write taken while full");
    property p_write_step;
        @(posedge port_a_clock) disable iff (!reset_n)
        a_fifo_wr |=> wr_bin_ff == $past(wr_bin_ff) + 7'h01;
    endproperty
    a_write_step: assert property (p_write_step)
        else $error("write pointer did not advance by one");
    property p_empty_blocks;
        @(posedge port_b_clock) disable iff (!reset_n)
        !empty_indicator_n |=> rd_bin_ff == $past(rd_bin_ff);
    endproperty
    a_empty_blocks: assert property (p_empty_blocks)
        else $error("read taken while empty");
    property p_near_empty;
        @(posedge port_b_clock) disable iff (!reset_n)
        ready_b_ff[1] && count_b <= offset_b_ff |-> !near_empty_flag_n;
    endproperty
    a_near_empty: assert property (p_near_empty)
        else $error("near empty flag high at low occupancy");
    property p_near_full;
        @(posedge port_a_clock) disable iff (!reset_n)
        (DEPTH_CNT - count_a) <= offset_a_ff |-> !near_full_flag_n;
    endproperty
    a_near_full: assert property (p_near_full)
        else $error("near full flag high with few free slots");
    property p_mail_one_flag;
        @(posedge port_a_clock) disable iff (!reset_n)
        a_mail1_wr |=> !mail_one_pending_n [*2];
    endproperty
    a_mail_one_flag: assert property (p_mail_one_flag)
        else $error("mail one flag not set after write");
    property p_select_release;
        @(posedge port_a_clock) disable iff (!reset_n)
        port_a_ctl.select_n |-> !port_a_bus_oe;
    endproperty
    a_select_release: assert property (p_select_release)
        else $error("port A bus driven while deselected");
    property p_parity_gen;
        @(posedge port_b_clock) disable iff (!reset_n)
        b_fifo_rd && port_b_parity_gen |=>
            parity_ok(port_b_bus_out, $past(parity_odd));
    endproperty
    a_parity_gen: assert property (p_parity_gen)
        else $error("generated parity wrong on port B read");

endmodule

// ===== dv/dcfm_far_b.sv
// Far side model of port B: a master that drains the queue and uses
// the mailboxes on command. Assumes cmd changes on its own clock edge.
`timescale 1ns/1ps
module dcfm_far_b (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [1:0] cmd,
    input wire dcfm_pkg::dcfm_word_t mb_data,
    input wire logic empty_n,
    input wire dcfm_pkg::dcfm_word_t bus_out,
    input wire logic bus_oe,
    output dcfm_pkg::dcfm_ctl_s ctl_ff,
    output dcfm_pkg::dcfm_word_t bus_in_ff,
    output logic got,
    output logic got_mail,
    output dcfm_pkg::dcfm_word_t got_word
);
    import dcfm_pkg::*;
    logic rd_q_ff; // Queue read taken at the last edge
    logic rd_m_ff; // Mailbox read taken at the last edge
    // A read result shows one edge after it is taken
    assign got = rd_q_ff | rd_m_ff;
    assign got_mail = rd_m_ff;
    // A bus the device does not drive drifts away from its last value
    assign got_word = bus_oe ? bus_out : ~bus_out;
    // Command 0 reads the queue with random gaps, 1 idles selected,
    // 2 reads mail one, 3 writes mail two
    always_ff @(posedge clk) begin
        rd_q_ff <= reset_n && !ctl_ff.select_n && ctl_ff.qualify &&
            !ctl_ff.write && !ctl_ff.mail_select && empty_n;
        rd_m_ff <= reset_n && !ctl_ff.select_n && ctl_ff.qualify &&
            !ctl_ff.write && ctl_ff.mail_select;
        if (!reset_n) begin
            ctl_ff <= '{1'b1, 1'b0, 1'b0, 1'b0};
            bus_in_ff <= 36'h0a5a5a5a5;
        end else begin
            case (cmd)
                2'h0: ctl_ff <= '{1'b0, ($urandom % 4) != 0, 1'b0, 1'b0};
                2'h2: ctl_ff <= '{1'b0, 1'b1, 1'b0, 1'b1};
                2'h3: ctl_ff <= '{1'b0, 1'b1, 1'b1, 1'b1};
                default: ctl_ff <= '{1'b0, 1'b0, 1'b0, 1'b0};
            endcase
            // Released bus changes every cycle
            bus_in_ff <= (cmd == 2'h3) ? mb_data : ~bus_in_ff;
        end
    end
endmodule

// ===== dv/dcfm_top_test.sv
// Self-checking bench for the dual clock queue with mailboxes.
// Assumes the port B master model sits in its own file.
`timescale 1ns/1ps
module dcfm_top_test;
    import dcfm_pkg::*;
    logic ca = 1'b0, cb = 1'b0, reset_n, odd, a_gen, b_gen;
    logic [1:0] strap, bcmd;
    dcfm_ctl_s actl, bctl;
    dcfm_word_t ain, aout, bin, bout, mbd, gword, xw, m1, w2, pbout;
    logic aoe, boe, full_n, nfull_n, empty_n, nempty_n, m1_n, m2_n;
    logic a_ok, b_ok, got, gmail, pa_exp;
    int n_fail = 0, compares = 0, off, k;
    dcfm_word_t mq[$]; // Model of the queue contents
    // Two unrelated free-running port clocks
    initial begin
        forever #12.5 ca = ~ca;
    end
    initial begin
        #7;
        forever #17.5 cb = ~cb;
    end
    dcfm_top dut_u (.port_a_clock(ca), .port_b_clock(cb), .reset_n,
        .offset_preset_select(strap), .parity_odd(odd),
        .port_a_parity_gen(a_gen), .port_b_parity_gen(b_gen),
        .port_a_ctl(actl), .port_b_ctl(bctl), .port_a_bus_in(ain),
        .port_a_bus_out(aout), .port_a_bus_oe(aoe), .port_b_bus_in(bin),
        .port_b_bus_out(bout), .port_b_bus_oe(boe),
        .full_indicator_n(full_n), .near_full_flag_n(nfull_n),
        .empty_indicator_n(empty_n), .near_empty_flag_n(nempty_n),
        .mail_one_pending_n(m1_n), .mail_two_pending_n(m2_n),
        .port_a_parity_ok(a_ok), .port_b_parity_ok(b_ok));
    dcfm_far_b far_u (.clk(cb), .reset_n, .cmd(bcmd), .mb_data(mbd),
        .empty_n, .bus_out(bout), .bus_oe(boe), .ctl_ff(bctl),
        .bus_in_ff(bin), .got, .got_mail(gmail), .got_word(gword));
    // Second device in parallel on inverted data, sharing all controls
    dcfm_top par_u (.port_a_clock(ca), .port_b_clock(cb), .reset_n,
        .offset_preset_select(strap), .parity_odd(odd),
        .port_a_parity_gen(a_gen), .port_b_parity_gen(b_gen),
        .port_a_ctl(actl), .port_b_ctl(bctl), .port_a_bus_in(~ain),
        .port_a_bus_out(), .port_a_bus_oe(), .port_b_bus_in(~bin),
        .port_b_bus_out(pbout), .port_b_bus_oe(), .full_indicator_n(),
        .near_full_flag_n(), .empty_indicator_n(), .near_empty_flag_n(),
        .mail_one_pending_n(), .mail_two_pending_n(),
        .port_a_parity_ok(), .port_b_parity_ok());
    // Lane parity bits recomputed for the chosen sense
    function automatic dcfm_word_t fixp(dcfm_word_t w, logic o);
        for (int l = 0; l < 4; l++) begin
            w[l*9+8] = (^w[l*9 +: 8]) ^ o;
        end
        return w;
    endfunction
    // Random word, now and then with one bad lane
    function automatic dcfm_word_t rw();
        dcfm_word_t w;
        w = fixp(36'({$urandom, $urandom}), odd);
        w[8] = w[8] ^ ($urandom % 4 == 0);
        return w;
    endfunction
    task automatic chk(string what, logic [35:0] e, logic [35:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cf(string what, logic e, logic g);
        chk(what, 36'(e), 36'(g));
    endtask
    // One port A request, taken at the following edge
    task automatic a_cyc(logic s, logic q, logic w, logic m, dcfm_word_t d);
        @(posedge ca);
        actl <= '{s, q, w, m};
        ain <= d;
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Port A model: queue writes and parity status
    always @(posedge ca) begin
        if (reset_n) begin
            cf("a_parity_ok", pa_exp, a_ok);
            if (!actl.select_n && actl.qualify && actl.write) begin
                pa_exp = (fixp(ain, odd) == ain);
                if (!actl.mail_select && mq.size() < 64) begin
                    mq.push_back(ain);
                end
            end
        end else begin
            pa_exp = 1'b1;
        end
    end
    // Port B results against the model
    always @(posedge cb) begin
        if (reset_n) begin
            cf("b_bus_oe", !bctl.select_n && !bctl.write, boe);
        end
        if (reset_n && got) begin
            if (gmail) begin
                chk("mail_one", m1, gword);
            end else if (mq.size() == 0) begin
                chk("queue_underrun", 36'h0, 36'h1);
            end else begin
                xw = mq.pop_front();
                chk("queue_word", b_gen ? fixp(xw, odd) : xw, gword);
                xw = ~xw;
                chk("wide", b_gen ? fixp(xw, odd) : xw, pbout);
            end
        end
    end
    // Flags against the model count of stored words
    task automatic flags();
        k = mq.size();
        cf("near_full", !((64 - k) <= off), nfull_n);
        cf("near_empty", !(k <= off), nempty_n);
        cf("full", k < 64, full_n);
        cf("empty", k > 0, empty_n);
    endtask
    task automatic drain();
        bcmd <= 2'h0;
        for (int i = 0; i < 3000 && mq.size() > 0; i++) begin
            @(posedge ca);
        end
        repeat (8) @(posedge ca);
        #1;
        flags();
        cf("drained", 1'b1, mq.size() == 0);
    endtask
    // Watchdog, about fifteen times the expected run
    initial begin
        #400000;
        n_fail++;
        test_done();
    end
    initial begin
        void'($urandom(32'h7e95fa09));
        strap = 2'($urandom_range(3));
        off = (strap == 0) ? 16 : (strap == 1) ? 12 : (strap == 2) ? 8 : 4;
        {reset_n, odd, a_gen, b_gen, bcmd} = {4'h2, 2'h1};
        actl = '{1'b1, 1'b0, 1'b0, 1'b0};
        {ain, mbd, pa_exp} = {72'h0, 1'b1};
        repeat (5) @(posedge ca);
        reset_n <= 1'b1;
        #1;
        cf("full_reset", 1'b0, full_n);
        cf("empty_reset", 1'b0, empty_n);
        @(posedge ca);
        #1;
        cf("full_release", 1'b0, full_n);
        @(posedge ca);
        #1;
        cf("full_release", 1'b1, full_n);
        repeat (6) @(posedge ca);
        #1;
        flags();
        cf("mail_reset", 1'b1, m1_n & m2_n);
        $display("reset test done");
        // Fill with the far side stalled, gaps and refusals included
        repeat (96) begin
            a_cyc($urandom % 8 == 0, $urandom % 8 != 0, 1'b1, 1'b0, rw());
            a_cyc(1'b1, 1'b0, 1'b0, 1'b0, rw());
            repeat (6) @(posedge ca);
            #1;
            flags();
        end
        $display("fill test done");
        @(posedge ca);
        odd <= 1'($urandom);
        b_gen <= 1'($urandom);
        drain();
        $display("drain test done");
        // Stream while the far side reads, writes back to back
        repeat (40) begin
            a_cyc($urandom % 6 == 0, $urandom % 6 != 0, 1'b1, 1'b0, rw());
        end
        a_cyc(1'b1, 1'b0, 1'b0, 1'b0, rw());
        drain();
        $display("stream test done");
        // Mailbox one: second write refused while pending
        bcmd <= 2'h1;
        b_gen <= 1'b0;
        a_gen <= 1'($urandom);
        m1 = rw();
        a_cyc(1'b0, 1'b1, 1'b1, 1'b1, m1);
        a_cyc(1'b0, 1'b1, 1'b1, 1'b1, ~m1);
        #1;
        cf("mail_one_set", 1'b0, m1_n);
        a_cyc(1'b1, 1'b0, 1'b0, 1'b0, rw());
        @(posedge cb);
        bcmd <= 2'h2;
        @(posedge cb);
        bcmd <= 2'h1;
        repeat (8) @(posedge ca);
        #1;
        cf("mail_one_clear", 1'b1, m1_n);
        // Mailbox two from port B to port A
        w2 = rw();
        @(posedge cb);
        mbd <= w2;
        bcmd <= 2'h3;
        @(posedge cb);
        bcmd <= 2'h1;
        repeat (8) @(posedge ca);
        #1;
        cf("mail_two_set", 1'b0, m2_n);
        cf("b_parity_ok", fixp(w2, odd) == w2, b_ok);
        a_cyc(1'b0, 1'b1, 1'b0, 1'b1, rw());
        a_cyc(1'b0, 1'b0, 1'b0, 1'b1, rw());
        #1;
        cf("a_drive", 1'b1, aoe);
        chk("mail_two", a_gen ? fixp(w2, odd) : w2, aout);
        a_cyc(1'b1, 1'b0, 1'b0, 1'b0, rw());
        #1;
        cf("a_release", 1'b0, aoe);
        repeat (8) @(posedge ca);
        #1;
        cf("mail_two_clear", 1'b1, m2_n);
        $display("mailbox test done");
        test_done();
    end
endmodule
